/* File: msr_pkg.sv */
package msr_pkg;
	// register byte offsets
	localparam logic [7:0]  MSR_OFS_CAP_HDR   = 8'hd0;
	localparam logic [7:0]  MSR_OFS_ADDR_LO   = 8'hd4;
	localparam logic [7:0]  MSR_OFS_ADDR_HI   = 8'hd8;
	localparam logic [7:0]  MSR_OFS_PAYLOAD   = 8'hdc;
	localparam logic [7:0]  MSR_OFS_SS_HDR    = 8'hf0;
	localparam logic [7:0]  MSR_OFS_SS_ID     = 8'hf4;
	localparam logic [7:0]  MSR_OFS_LOCK      = 8'he0;
	localparam logic [7:0]  MSR_OFS_TRIGGER   = 8'he4;
	localparam logic [7:0]  MSR_OFS_STATUS    = 8'he8;
	// fixed field values
	localparam logic [7:0]  MSR_MSI_CAP_ID    = 8'h05;
	localparam logic [7:0]  MSR_SS_CAP_ID     = 8'h0d;
	localparam logic [2:0]  MSR_REQ_MSG_CNT   = 3'h0;
	localparam logic        MSR_WIDE_CAPABLE  = 1'h1;
	// reset values
	localparam logic [7:0]  MSR_RST_NXT_PTR   = 8'h00;
	localparam logic [2:0]  MSR_RST_ALLOC     = 3'h0;
	localparam logic [29:0] MSR_RST_ADDR_LO   = 30'h0;
	localparam logic [31:0] MSR_RST_ADDR_HI   = 32'h0;
	localparam logic [15:0] MSR_RST_PAYLOAD   = 16'h0;
	localparam logic [15:0] MSR_RST_SS_VENDOR = 16'h0;
	localparam logic [15:0] MSR_RST_SS_ID     = 16'h0;
	// field positions in the capability header
	localparam int          MSR_POS_NXT       = 8;
	localparam int          MSR_POS_EN        = 16;
	localparam int          MSR_POS_REQ       = 17;
	localparam int          MSR_POS_ALLOC     = 20;
	localparam int          MSR_POS_WIDE      = 23;
endpackage

/* File: msr_msg_gen.sv */
`timescale 1ns/1ps
// builds one interrupt memory write toward the upstream port
module msr_msg_gen (
	input  wire logic        core_clk,
	input  wire logic        srst,
	input  wire logic        event_pulse,
	input  wire logic        msg_enable,
	input  wire logic [29:0] addr_lo,
	input  wire logic [31:0] addr_hi,
	input  wire logic [15:0] payload,
	output logic             msg_valid,
	input  wire logic        msg_ready,
	output logic [63:0]      msg_addr,
	output logic             msg_wide,
	output logic [31:0]      msg_data,
	output logic             msg_upstream,
	output logic             msg_dropped
);
	import msr_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// one pending write at a time; events while pending merge into it
	always_ff @(posedge core_clk) begin
		if (srst) begin
			msg_valid    <= 1'b0;
			msg_addr     <= 64'h0;
			msg_wide     <= 1'b0;
			msg_data     <= 32'h0;
			msg_upstream <= 1'b0;
		end else if (event_pulse && msg_enable && !msg_valid) begin
			msg_valid    <= 1'b1;
			msg_wide     <= (addr_hi != 32'h0);
			msg_addr     <= (addr_hi != 32'h0) ? {addr_hi, addr_lo, 2'b00}
				: {32'h0, addr_lo, 2'b00};
			msg_data     <= {16'h0, payload};
			msg_upstream <= 1'b1;
		end else if (msg_valid && msg_ready) begin
			msg_valid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// an event with the enable off produces no write, only a flag pulse
	always_ff @(posedge core_clk) begin
		if (srst) begin
			msg_dropped <= 1'b0;
		end else begin
			msg_dropped <= event_pulse && !msg_enable;
		end
	end

	chk_enable_gates: assert property (@(posedge core_clk) disable iff (srst)
		(event_pulse && !msg_enable && !msg_valid) |=> !msg_valid)
		else $error("message issued while disabled");
	chk_narrow_addr: assert property (@(posedge core_clk) disable iff (srst)
		$rose(msg_valid) |-> (msg_wide == (msg_addr[63:32] != 32'h0)))
		else $error("address width mismatch");
	chk_data_upper: assert property (@(posedge core_clk) disable iff (srst)
		msg_valid |-> (msg_data[31:16] == 16'h0 && msg_addr[1:0] == 2'b00))
		else $error("payload or alignment wrong");
	chk_route_up: assert property (@(posedge core_clk) disable iff (srst)
		msg_valid |-> msg_upstream)
		else $error("message not routed upstream");
	cov_wide_msg: cover property (@(posedge core_clk) disable iff (srst)
		$rose(msg_valid) && msg_wide);
	cov_narrow_msg: cover property (@(posedge core_clk) disable iff (srst)
		$rose(msg_valid) && !msg_wide);
endmodule // msr_msg_gen

/* File: msr_regs.sv */
`timescale 1ns/1ps
// Behaviour
// - interrupt header low byte reads 0x05
// - next pointer bits 15:8, default zero
// - enable bit 16 gates message writes
// - requested count bits 19:17 read zero
// - allocated count stored, one message always
// - bit 23 reads one, wide capable
// - lower address 31:2, bits 1:0 zero
// - every message write goes upstream
// - nonzero upper address selects wide write
// - 16-bit payload in message low half
// - subsystem header low byte reads 0x0d
// - subsystem next pointer lockable, upper zero
// - vendor identifier bits 15:0, lockable
// - subsystem identifier bits 31:16, lockable
module msr_regs (
	input  wire logic        core_clk,
	input  wire logic        srst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	input  wire logic        event_pulse,
	output logic             msg_valid,
	input  wire logic        msg_ready,
	output logic [63:0]      msg_addr,
	output logic             msg_wide,
	output logic [31:0]      msg_data,
	output logic             msg_upstream
);
	import msr_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// register state
	logic [7:0]  nxt_ptr_r;        // interrupt next pointer
	logic        msg_en_r;         // interrupt enable
	logic [2:0]  alloc_cnt_r;      // allocated count, stored only
	logic [29:0] addr_lo_r;        // lower address, dword units
	logic [31:0] addr_hi_r;        // upper address
	logic [15:0] payload_r;        // message payload value
	logic [7:0]  ss_nxt_ptr_r;     // subsystem next pointer
	logic [15:0] ss_vendor_r;      // subsystem vendor identifier
	logic [15:0] ss_ident_r;       // subsystem identifier
	logic        lock_r;           // locks the lockable fields
	logic [7:0]  sent_cnt_r;       // count of issued messages
	logic        drop_seen_r;      // sticky: event while disabled
	logic        sw_trig;          // software event pulse
	logic        msg_dropped;      // generator drop pulse
	logic        access;           // access phase
	logic        wr_en;            // write in access phase
	logic [7:0]  word_ofs;         // word-aligned offset
	logic        mapped;           // address decodes
	logic [31:0] cap_hdr;          // assembled headers
	logic [31:0] ss_hdr;

	////////////////////////////////////////////////////////////////////////////
	// apb decode: zero wait state, unmapped answers with an error
	assign access   = psel && penable;
	assign wr_en    = access && pwrite && mapped;
	assign word_ofs = {paddr[7:2], 2'b00};
	assign pready   = 1'b1;
	assign mapped   = (paddr[11:8] == 4'h0) && (paddr[1:0] == 2'b00) &&
		(word_ofs == MSR_OFS_CAP_HDR || word_ofs == MSR_OFS_ADDR_LO ||
		 word_ofs == MSR_OFS_ADDR_HI || word_ofs == MSR_OFS_PAYLOAD ||
		 word_ofs == MSR_OFS_SS_HDR  || word_ofs == MSR_OFS_SS_ID ||
		 word_ofs == MSR_OFS_LOCK    || word_ofs == MSR_OFS_TRIGGER ||
		 word_ofs == MSR_OFS_STATUS);
	assign pslverr  = access && !mapped;
	assign sw_trig  = wr_en && (word_ofs == MSR_OFS_TRIGGER) && pstrb[0] && pwdata[0];

	// header words are built from constants and stored fields
	assign cap_hdr = {8'h00, MSR_WIDE_CAPABLE, alloc_cnt_r, MSR_REQ_MSG_CNT,
		msg_en_r, nxt_ptr_r, MSR_MSI_CAP_ID};
	assign ss_hdr  = {16'h0000, ss_nxt_ptr_r, MSR_SS_CAP_ID};

	////////////////////////////////////////////////////////////////////////////
	// interrupt capability header fields
	always_ff @(posedge core_clk) begin
		if (srst) begin
			nxt_ptr_r   <= MSR_RST_NXT_PTR;
			msg_en_r    <= 1'b0;
			alloc_cnt_r <= MSR_RST_ALLOC;
		end else if (wr_en && word_ofs == MSR_OFS_CAP_HDR) begin
			// next pointer only writable while unlocked
			if (pstrb[1] && !lock_r) begin
				nxt_ptr_r <= pwdata[MSR_POS_NXT +: 8];
			end
			if (pstrb[2]) begin
				msg_en_r    <= pwdata[MSR_POS_EN];
				// stored for readback; one message is used regardless
				alloc_cnt_r <= pwdata[MSR_POS_ALLOC +: 3];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// message address and payload, byte-lane writes
	always_ff @(posedge core_clk) begin
		if (srst) begin
			addr_lo_r <= MSR_RST_ADDR_LO;
			addr_hi_r <= MSR_RST_ADDR_HI;
			payload_r <= MSR_RST_PAYLOAD;
		end else if (wr_en) begin
			for (int b = 0; b < 4; b++) begin
				if (pstrb[b] && word_ofs == MSR_OFS_ADDR_HI) begin
					addr_hi_r[b*8 +: 8] <= pwdata[b*8 +: 8];
				end
			end
			if (word_ofs == MSR_OFS_ADDR_LO) begin
				// bits 1:0 are not stored so the target stays dword aligned
				if (pstrb[0]) addr_lo_r[5:0]   <= pwdata[7:2];
				if (pstrb[1]) addr_lo_r[13:6]  <= pwdata[15:8];
				if (pstrb[2]) addr_lo_r[21:14] <= pwdata[23:16];
				if (pstrb[3]) addr_lo_r[29:22] <= pwdata[31:24];
			end
			if (word_ofs == MSR_OFS_PAYLOAD) begin
				if (pstrb[0]) payload_r[7:0]  <= pwdata[7:0];
				if (pstrb[1]) payload_r[15:8] <= pwdata[15:8];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// subsystem identification, lockable
	always_ff @(posedge core_clk) begin
		if (srst) begin
			ss_nxt_ptr_r <= MSR_RST_NXT_PTR;
			ss_vendor_r  <= MSR_RST_SS_VENDOR;
			ss_ident_r   <= MSR_RST_SS_ID;
		end else if (wr_en && !lock_r) begin
			if (word_ofs == MSR_OFS_SS_HDR && pstrb[1]) begin
				ss_nxt_ptr_r <= pwdata[15:8];
			end
			if (word_ofs == MSR_OFS_SS_ID) begin
				if (pstrb[0]) ss_vendor_r[7:0]  <= pwdata[7:0];
				if (pstrb[1]) ss_vendor_r[15:8] <= pwdata[15:8];
				if (pstrb[2]) ss_ident_r[7:0]   <= pwdata[23:16];
				if (pstrb[3]) ss_ident_r[15:8]  <= pwdata[31:24];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// lock control; once set it holds until reset
	always_ff @(posedge core_clk) begin
		if (srst) begin
			lock_r <= 1'b0;
		end else if (wr_en && word_ofs == MSR_OFS_LOCK && pstrb[0] && pwdata[0]) begin
			lock_r <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// status: issued count and sticky drop flag; set wins over clear
	always_ff @(posedge core_clk) begin
		if (srst) begin
			sent_cnt_r  <= 8'h00;
			drop_seen_r <= 1'b0;
		end else begin
			if (msg_valid && msg_ready) begin
				sent_cnt_r <= sent_cnt_r + 8'h01;
			end
			if (msg_dropped) begin
				drop_seen_r <= 1'b1;
			end else if (wr_en && word_ofs == MSR_OFS_STATUS && pstrb[1] && pwdata[8]) begin
				drop_seen_r <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// read data registered during setup so it is valid in access phase
	always_ff @(posedge core_clk) begin
		if (srst) begin
			prdata <= 32'h0;
		end else if (psel && !penable && !pwrite) begin
			// unmapped reads fall to the default so aliases never leak data
			case (mapped ? word_ofs : 8'h00)
				MSR_OFS_CAP_HDR: prdata <= cap_hdr;
				MSR_OFS_ADDR_LO: prdata <= {addr_lo_r, 2'b00};
				MSR_OFS_ADDR_HI: prdata <= addr_hi_r;
				MSR_OFS_PAYLOAD: prdata <= {16'h0000, payload_r};
				MSR_OFS_SS_HDR:  prdata <= ss_hdr;
				MSR_OFS_SS_ID:   prdata <= {ss_ident_r, ss_vendor_r};
				MSR_OFS_LOCK:    prdata <= {31'h0, lock_r};
				MSR_OFS_STATUS:  prdata <= {23'h0, drop_seen_r, sent_cnt_r};
				default:         prdata <= 32'h0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// message generator; events come from a pin or software trigger
	msr_msg_gen msr_msg_gen_i (
		.core_clk     (core_clk),
		.srst         (srst),
		.event_pulse  (event_pulse || sw_trig),
		.msg_enable   (msg_en_r),
		.addr_lo      (addr_lo_r),
		.addr_hi      (addr_hi_r),
		.payload      (payload_r),
		.msg_valid    (msg_valid),
		.msg_ready    (msg_ready),
		.msg_addr     (msg_addr),
		.msg_wide     (msg_wide),
		.msg_data     (msg_data),
		.msg_upstream (msg_upstream),
		.msg_dropped  (msg_dropped)
	);

	////////////////////////////////////////////////////////////////////////////
	// checks; all on the core clock, quiet while reset is held
	// constant header fields, whatever software writes over them
	chk_cap_id_ro: assert property (@(posedge core_clk) disable iff (srst)
		cap_hdr[7:0] == MSR_MSI_CAP_ID && cap_hdr[23] && cap_hdr[19:17] == 3'h0)
		else $error("interrupt header constant fields wrong");
	// subsystem header: fixed id, upper half zero
	chk_ss_hdr_ro: assert property (@(posedge core_clk) disable iff (srst)
		ss_hdr[7:0] == MSR_SS_CAP_ID && ss_hdr[31:16] == 16'h0)
		else $error("subsystem header constant fields wrong");
	// identifiers frozen once the lock is set
	chk_lock_holds: assert property (@(posedge core_clk) disable iff (srst)
		lock_r |=> $stable(ss_vendor_r) && $stable(ss_ident_r))
		else $error("locked identifier changed");
	// both next pointers frozen once locked
	chk_lock_nxt_ptr: assert property (@(posedge core_clk) disable iff (srst)
		lock_r |=> $stable(nxt_ptr_r) && $stable(ss_nxt_ptr_r))
		else $error("locked next pointer changed");
	// enable follows lane 2 writes, locked or not
	chk_en_write: assert property (@(posedge core_clk) disable iff (srst)
		(wr_en && word_ofs == MSR_OFS_CAP_HDR && pstrb[2])
		|=> msg_en_r == $past(pwdata[MSR_POS_EN]))
		else $error("enable bit not written");
	// payload captured at the event edge travels with the write
	chk_payload_out: assert property (@(posedge core_clk) disable iff (srst)
		$rose(msg_valid) |-> msg_data[15:0] == $past(payload_r))
		else $error("payload not carried");
	// no write leaves while the enable bit was off at the event
	chk_rise_needs_en: assert property (@(posedge core_clk) disable iff (srst)
		$rose(msg_valid) |-> $past(msg_en_r))
		else $error("message without enable");
	// lower address readback keeps the two low bits at zero
	chk_addr_lo_align: assert property (@(posedge core_clk) disable iff (srst)
		(access && !pwrite && mapped && word_ofs == MSR_OFS_ADDR_LO) |-> prdata[1:0] == 2'b00)
		else $error("lower address not aligned");
	// payload register upper half reads zero
	chk_payload_rd: assert property (@(posedge core_clk) disable iff (srst)
		(access && !pwrite && mapped && word_ofs == MSR_OFS_PAYLOAD) |-> prdata[31:16] == 16'h0)
		else $error("payload upper half not zero");
	// allocated count never shapes the write: one dword, upper half zero
	chk_one_vector: assert property (@(posedge core_clk) disable iff (srst)
		msg_valid |-> msg_data[31:16] == 16'h0)
		else $error("message shape depends on allocated count");
	// unmapped accesses answer with an error and never write
	chk_unmapped_err: assert property (@(posedge core_clk) disable iff (srst)
		(access && !mapped) |-> pslverr && !wr_en)
		else $error("unmapped access not refused");
	// zero wait state: the answer is always ready
	chk_ready_high: assert property (@(posedge core_clk) disable iff (srst)
		access |-> pready)
		else $error("ready low in access phase");
	// drop flag: a set in the same cycle as a clear still wins
	chk_drop_sticky: assert property (@(posedge core_clk) disable iff (srst)
		msg_dropped |=> drop_seen_r)
		else $error("drop flag not set");
	// issued counter moves by one per accepted write
	chk_sent_count: assert property (@(posedge core_clk) disable iff (srst)
		(msg_valid && msg_ready) |=> sent_cnt_r == $past(sent_cnt_r) + 8'h01)
		else $error("issued count wrong");
	// trigger register always reads zero
	chk_trig_reads_zero: assert property (@(posedge core_clk) disable iff (srst)
		(access && !pwrite && mapped && word_ofs == MSR_OFS_TRIGGER) |-> prdata == 32'h0)
		else $error("trigger register not zero");
	// main scenarios
	cov_msg_sent: cover property (@(posedge core_clk) disable iff (srst)
		msg_valid && msg_ready);
	cov_locked_wr: cover property (@(posedge core_clk) disable iff (srst)
		lock_r && wr_en && word_ofs == MSR_OFS_SS_ID);
	cov_sw_trigger: cover property (@(posedge core_clk) disable iff (srst)
		sw_trig && msg_en_r);
endmodule // msr_regs

/* File: msr_sink.sv */
`timescale 1ns/1ps
// upstream message path model: accepts writes with random stalls
module msr_sink (
	input  wire logic        core_clk,
	input  wire logic        srst,
	input  wire logic        msg_valid,
	input  wire logic [63:0] msg_addr,
	input  wire logic        msg_wide,
	input  wire logic [31:0] msg_data,
	input  wire logic        msg_upstream,
	output logic             msg_ready,
	output logic [63:0]      got_addr,
	output logic             got_wide,
	output logic [31:0]      got_data,
	output logic             got_up,
	output logic [7:0]       got_cnt
);
	////////////////////////////////////////////////////////////////
	// random backpressure, so held fields must stay put while stalled
	always @(posedge core_clk) begin
		msg_ready <= srst ? 1'b0 : ($urandom % 3 == 0);
	end
	// capture only at the accepting edge
	always @(posedge core_clk) begin
		if (srst) begin
			got_cnt <= 8'h00;
		end else if (msg_valid && msg_ready) begin
			got_cnt  <= got_cnt + 8'h01;
			got_addr <= msg_addr;
			got_wide <= msg_wide;
			got_data <= msg_data;
			got_up   <= msg_upstream;
		end
	end
endmodule // msr_sink

/* File: msi_and_subsystem_id_regs_tb_top.sv */
`timescale 1ns/1ps
module msi_and_subsystem_id_regs_tb_top;
	import msr_pkg::*;
	logic        core_clk, srst, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q, lo, hi, pd;
	logic        event_pulse, msg_valid, msg_ready, msg_wide, msg_upstream, e, en;
	logic [63:0] msg_addr, got_addr;
	logic [31:0] msg_data, got_data;
	logic        got_wide, got_up;
	logic [7:0]  got_cnt, n0;
	logic [2:0]  al;
	int          errors, checks, i, n, ns, nd;
	logic [3:0]  pstrb;
	// register table: offset, reset value, after all-ones, after lock and zero write
	logic [7:0]  ofs[6]   = '{MSR_OFS_CAP_HDR, MSR_OFS_ADDR_LO, MSR_OFS_ADDR_HI,
		MSR_OFS_PAYLOAD, MSR_OFS_SS_HDR, MSR_OFS_SS_ID};
	logic [31:0] rst_v[6] = '{32'h00800005, 32'h0, 32'h0, 32'h0, 32'h0000000d, 32'h0};
	logic [31:0] one_v[6] = '{32'h00f1ff05, 32'hfffffffc, 32'hffffffff, 32'h0000ffff,
		32'h0000ff0d, 32'hffffffff};
	logic [31:0] lck_v[6] = '{32'h0080ff05, 32'h0, 32'h0, 32'h0, 32'h0000ff0d, 32'hffffffff};

	msr_regs msr_regs_i (.core_clk(core_clk), .srst(srst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .event_pulse(event_pulse),
		.msg_valid(msg_valid), .msg_ready(msg_ready), .msg_addr(msg_addr),
		.msg_wide(msg_wide), .msg_data(msg_data), .msg_upstream(msg_upstream));
	msr_sink msr_sink_i (.core_clk(core_clk), .srst(srst), .msg_valid(msg_valid),
		.msg_addr(msg_addr), .msg_wide(msg_wide), .msg_data(msg_data),
		.msg_upstream(msg_upstream), .msg_ready(msg_ready), .got_addr(got_addr),
		.got_wide(got_wide), .got_data(got_data), .got_up(got_up), .got_cnt(got_cnt));

	////////////////////////////////////////////////////////////////
	// 40 MHz core clock
	always #12.5 core_clk = ~core_clk;

	// closing report, the only exit
	task finish_test;
		$display("errors=%0d checks=%0d", errors, checks);
		if (errors == 0 && checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// expected message address from the two address registers
	function automatic logic [63:0] exp_addr(input logic [31:0] l, input logic [31:0] h);
		return {h, l[31:2], 2'b00};
	endfunction
	// compare and count
	task chk(input logic [63:0] got, input logic [63:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one apb transfer: setup, access held until pready sampled high
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge core_clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= {4'h0, a};
		pwdata  <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge core_clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (k >= 20) begin
			errors++;
			finish_test;
		end
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		core_clk = 0; srst = 1; psel = 0; penable = 0; pwrite = 0;
		paddr = 0; pwdata = 0; event_pulse = 0; errors = 0; checks = 0;
		pstrb = 4'hf; ns = 0; nd = 0;
		void'($urandom(74));
		repeat (16) @(posedge core_clk);
		srst <= 1'b0;
		// reset values of the six registers in the table
		for (i = 0; i < 6; i++) begin
			apb(1'b0, ofs[i], 32'h0);
			chk(q, rst_v[i]);
		end
		// byte lanes: only lane 1 of the payload may change
		pstrb <= 4'h2;
		apb(1'b1, MSR_OFS_PAYLOAD, 32'habcd1234);
		pstrb <= 4'hf;
		apb(1'b0, MSR_OFS_PAYLOAD, 32'h0);
		chk(q, 32'h00001200);
		// all ones: read-only bits must not move
		for (i = 0; i < 6; i++) begin
			apb(1'b1, ofs[i], 32'hffffffff);
			apb(1'b0, ofs[i], 32'h0);
			chk(q, one_v[i]);
		end
		// unmapped offset is refused with an error and zero data
		apb(1'b0, 8'hc0, 32'h0);
		chk(64'({e, q}), 64'({1'b1, 32'h0}));
		// lock, then zero writes leave lockable fields alone
		apb(1'b1, MSR_OFS_LOCK, 32'h1);
		for (i = 0; i < 6; i++) begin
			apb(1'b1, ofs[i], 32'h0);
			apb(1'b0, ofs[i], 32'h0);
			chk(q, lck_v[i]);
		end
		// random messages, narrow and wide, some disabled
		for (i = 0; i < 12; i++) begin
			lo = $urandom;
			hi = ($urandom % 2) ? $urandom : 32'h0;
			pd = $urandom;
			al = 3'($urandom);
			en = (i < 2) || ($urandom % 4 != 0);
			if (i == 0) begin
				lo = 32'hffffffff;
				hi = 32'h0;
			end
			if (i == 1) hi = 32'h1;
			n0 = got_cnt;
			apb(1'b1, MSR_OFS_CAP_HDR, {8'h0, 1'b0, al, 3'h0, en, 16'h0});
			apb(1'b1, MSR_OFS_ADDR_LO, lo);
			apb(1'b1, MSR_OFS_ADDR_HI, hi);
			apb(1'b1, MSR_OFS_PAYLOAD, pd);
			@(posedge core_clk) event_pulse <= 1'b1;
			@(posedge core_clk) event_pulse <= 1'b0;
			for (n = 0; n < 40 && got_cnt == n0; n++) @(posedge core_clk);
			if (en && n >= 40) begin
				errors++;
				finish_test;
			end else if (en) begin
				ns++;
				chk(got_addr, exp_addr(lo, hi));
				chk(64'(got_wide), 64'(hi != 0));
				chk(64'(got_data), {48'h0, pd[15:0]});
				chk(64'(got_up), 64'h1);
			end else begin
				nd++;
				chk(64'(n), 64'd40);
			end
		end
		// status: issued count and sticky drop flag, then clear the flag
		apb(1'b0, MSR_OFS_STATUS, 32'h0);
		chk(q, {23'h0, nd != 0, 8'(ns)});
		apb(1'b1, MSR_OFS_STATUS, 32'h100);
		apb(1'b0, MSR_OFS_STATUS, 32'h0);
		chk(q, {23'h0, 1'b0, 8'(ns)});
		apb(1'b0, MSR_OFS_LOCK, 32'h0);
		chk(q, 32'h1);
		apb(1'b0, MSR_OFS_TRIGGER, 32'h0);
		chk(q, 32'h0);
		// software trigger with the enable on sends the last programmed write
		apb(1'b1, MSR_OFS_CAP_HDR, 32'h00010000);
		n0 = got_cnt;
		apb(1'b1, MSR_OFS_TRIGGER, 32'h1);
		for (n = 0; n < 40 && got_cnt == n0; n++) @(posedge core_clk);
		if (n >= 40) begin
			errors++;
			finish_test;
		end
		chk(got_addr, exp_addr(lo, hi));
		chk(64'(got_data), {48'h0, pd[15:0]});
		finish_test;
	end
endmodule // msi_and_subsystem_id_regs_tb_top
